/* hw/hst_pkg.sv */
package hst_pkg;
   // -----------------------------------------------------------------
   // Probe geometry
   // -----------------------------------------------------------------
   localparam int SEC_W = 8;
   localparam int NSEC = 12;
   localparam int CH_W = 96;
   localparam int HS_W = 48;
   localparam int FAST_W = 24;
   // Section bits: A0..A3 = 0..3, D0..D3 = 4..7, C0..C3 = 8..11
   localparam logic [11:0] MASK_GP = 12'hfff;
   localparam logic [11:0] MASK_HS = 12'h30f;
   localparam logic [11:0] MASK_FAST = 12'h103;
   // -----------------------------------------------------------------
   // Sample period codes, fastest first; code 9 is 1 ms
   // -----------------------------------------------------------------
   localparam logic [3:0] PER_2P5 = 4'h0;
   localparam logic [3:0] PER_5 = 4'h1;
   localparam logic [3:0] PER_10 = 4'h2;
   localparam logic [3:0] PER_1MS = 4'h9;
   // -----------------------------------------------------------------
   // Trigger position tolerance in samples, depth scaling
   // -----------------------------------------------------------------
   localparam logic [1:0] TOL_GP = 2'h0;
   localparam logic [1:0] TOL_HS = 2'h1;
   localparam logic [1:0] TOL_FAST = 2'h3;
   localparam logic [1:0] DSH_GP = 2'h0;
   localparam logic [1:0] DSH_HS = 2'h1;
   localparam logic [1:0] DSH_FAST = 2'h2;
   localparam logic [3:0] DEPTH_EXP_MAX = 4'h9;
   localparam int BASE_DEPTH = 32768;
   localparam int DEPTH_W = 18;
   localparam int FIFO_DEPTH = 4;
   localparam logic [3:0] HIST_N = 4'h8;
endpackage

/* hw/hs_trigger.sv */
`timescale 1ns/1ps
`default_nettype none

// Shift-style FIFO: the head word is always a flop
module smp_fifo #(
   parameter int W = 96,
   parameter int D = 4
) (
   input wire logic sys_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic in_valid, // write request
   input wire logic [W-1:0] in_data, // write word
   output logic in_ready, // room left
   output logic out_valid, // head valid
   output logic [W-1:0] out_data, // head word
   input wire logic out_ready // sink takes head
);
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_q [D];
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   initial if (D < 2 || W < 1) $error("smp_fifo: bad size");

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[0];

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) cnt_d = cnt_q + CW'(1);
      if (pop && !push) cnt_d = cnt_q - CW'(1);
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_q <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         in_ready <= cnt_d < CW'(D);
         out_valid <= cnt_d != '0;
      end
   end

   for (genvar i = 0; i < D; i++) begin : g_slot
      always_ff @(posedge sys_clk) begin
         if (pop) begin
            if (push && CW'(i + 1) == cnt_q) mem_q[i] <= in_data;
            else if (i < D - 1) mem_q[i] <= mem_q[(i + 1) % D];
         end else if (push && CW'(i) == cnt_q) begin
            mem_q[i] <= in_data;
         end
      end
   end
endmodule // smp_fifo

// Behaviour
// - Slower high-speed periods enable address sections 3..0 and control 1..0 only.
// - At 2.5 ns only address 1..0 and control 0 stay enabled.
// - High-speed mode uses internal clock only; 5 and 2.5 ns refused otherwise.
// - Trigger tolerance: 1 sample at 5 ns, 3 at 2.5 ns, 0 general.
// - Defined trigger cleared if above new depth; never exceeds depth.
// - High-speed narrows event widths and offers no range events.
// - Inactive channels never take part in channel or consecutive events.
// - Consecutive section is 48 channels wide, 24 at 2.5 ns.
// - Slower periods: samples N,N+1 equal N+2,N+3 raises consecutive event.
// - At 2.5 ns: samples N..N+3 equal N+4..N+7 raises the event.
// - General mode limits sampling to 10 ns, so events stay reliable.
// - 2.5 ns changes both active width and memory depth.
// - High-speed depth is twice general, four times at 2.5 ns.
module hs_trigger
   import hst_pkg::*;
#(
   parameter int BASE = hst_pkg::BASE_DEPTH
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic nrst, // sync reset
   input wire logic hs_mode, // high-speed timing select
   input wire logic [3:0] period_sel, // requested period code
   input wire logic ext_clk_req, // external clock wanted
   input wire logic [3:0] depth_exp, // depth = base >> exp, x2 in high-speed, x4 at 2.5 ns
   input wire logic def_trig_wr, // load defined trigger
   input wire logic [hst_pkg::DEPTH_W-1:0] def_trig_val, // defined trigger
   input wire logic word_en, // word event on
   input wire logic [hst_pkg::CH_W-1:0] word_val, // word pattern
   input wire logic [hst_pkg::CH_W-1:0] word_care, // word care mask
   input wire logic chan_en, // channel event on
   input wire logic [6:0] chan_idx, // channel number
   input wire logic chan_lvl, // wanted level
   input wire logic consec_en, // consecutive event on
   input wire logic range_en, // range event wanted
   input wire logic smp_valid, // sample offered
   input wire logic [hst_pkg::CH_W-1:0] smp_data, // sample word
   output logic smp_ready, // sample taken
   output logic out_valid, // stored sample valid
   output logic [hst_pkg::CH_W-1:0] out_data, // stored sample
   input wire logic out_ready, // sink ready
   output logic [11:0] sec_en, // enabled sections
   output logic [3:0] period_eff, // period in use
   output logic period_err, // request refused
   output logic ext_clk_used, // external clocking
   output logic [1:0] pos_tol, // trigger tolerance
   output logic [hst_pkg::DEPTH_W-1:0] mem_depth, // depth in cycles
   output logic [hst_pkg::DEPTH_W-1:0] def_trig, // defined trigger
   output logic range_avail, // range events offered
   output logic range_on, // range event armed
   output logic word_hit, // word event pulse
   output logic chan_hit, // channel event pulse
   output logic consec_hit, // consecutive pulse
   output logic trig, // trigger pulse
   output logic [hst_pkg::DEPTH_W-1:0] trig_pos // sample index of trigger
);
   import hst_pkg::*;

   initial if (BASE * 4 >= 2 ** DEPTH_W || BASE < 512) $error("hs_trigger: bad BASE");

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [CH_W-1:0] expand(input logic [11:0] m);
      logic [CH_W-1:0] r;
      r = '0;
      for (int s = 0; s < NSEC; s++) r[s*SEC_W +: SEC_W] = {SEC_W{m[s]}};
      return r;
   endfunction

   // Packs the active sections of the consecutive selection into 48 bits
   function automatic logic [HS_W-1:0] pack(input logic [CH_W-1:0] d, input logic f);
      logic [HS_W-1:0] r;
      r = '0;
      if (f) r[FAST_W-1:0] = {d[71:64], d[15:0]};
      else r = {d[79:64], d[31:0]};
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Mode and period
   // ----------------------------------------------------------------
   logic hs_q, fast_q, fast_d, perr_d;
   logic [3:0] per_d;
   logic [CH_W-1:0] chmask;

   always_comb begin
      per_d = period_sel > PER_1MS ? PER_1MS : period_sel;
      perr_d = 1'b0;
      if (!hs_mode && per_d < PER_10) begin
         per_d = PER_10;
         perr_d = 1'b1;
      end
      fast_d = hs_mode && per_d == PER_2P5;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hs_q <= 1'b0;
         fast_q <= 1'b0;
         period_eff <= PER_10;
         period_err <= 1'b0;
         ext_clk_used <= 1'b0;
         sec_en <= MASK_GP;
         pos_tol <= TOL_GP;
         range_avail <= 1'b1;
         range_on <= 1'b0;
      end else begin
         hs_q <= hs_mode;
         fast_q <= fast_d;
         period_eff <= per_d;
         period_err <= perr_d;
         ext_clk_used <= ext_clk_req && !hs_mode;
         sec_en <= fast_d ? MASK_FAST : hs_mode ? MASK_HS : MASK_GP;
         pos_tol <= fast_d ? TOL_FAST : hs_mode ? TOL_HS : TOL_GP;
         range_avail <= !hs_mode;
         range_on <= range_en && !hs_mode;
      end
   end

   assign chmask = expand(sec_en);

   // ----------------------------------------------------------------
   // Memory depth and defined trigger
   // ----------------------------------------------------------------
   logic [DEPTH_W-1:0] depth_d;
   logic [3:0] dexp;
   logic [1:0] dsh;

   always_comb begin
      dexp = depth_exp > DEPTH_EXP_MAX ? DEPTH_EXP_MAX : depth_exp;
      dsh = fast_d ? DSH_FAST : hs_mode ? DSH_HS : DSH_GP;
      depth_d = (DEPTH_W'(BASE) >> dexp) << dsh;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         mem_depth <= DEPTH_W'(BASE);
         def_trig <= '0;
      end else begin
         mem_depth <= depth_d;
         if (def_trig_wr) def_trig <= def_trig_val > depth_d ? depth_d : def_trig_val;
         else if (def_trig > depth_d) def_trig <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Sample path through the FIFO
   // ----------------------------------------------------------------
   // Source must hold smp_valid until smp_ready; a full FIFO stalls it
   logic take;
   logic [CH_W-1:0] smp_m;

   assign take = smp_valid && smp_ready;
   assign smp_m = smp_data & chmask;

   smp_fifo #(.W(CH_W), .D(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(smp_valid),
      .in_data(smp_m),
      .in_ready(smp_ready),
      .out_valid(out_valid),
      .out_data(out_data),
      .out_ready(out_ready)
   );

   // ----------------------------------------------------------------
   // Consecutive-cycle history
   // ----------------------------------------------------------------
   // Fill count cleared on a mode change so stale samples of another width never match
   logic [HS_W-1:0] hist_q [8];
   logic [HS_W-1:0] cur;
   logic [3:0] fill_q;
   logic cfg_chg, pair_eq, quad_eq, csc_d;

   assign cfg_chg = hs_q != hs_mode || fast_q != fast_d;
   assign cur = pack(smp_m, fast_q);

   always_ff @(posedge sys_clk) begin
      if (!nrst || cfg_chg) fill_q <= '0;
      else if (take && fill_q < HIST_N) fill_q <= fill_q + 4'h1;
   end

   always_ff @(posedge sys_clk) begin
      if (take) begin
         hist_q[0] <= cur;
         for (int i = 1; i < 8; i++) hist_q[i] <= hist_q[i-1];
      end
   end

   // cur is sample N+3 (or N+7); history holds the older ones
   assign pair_eq = {hist_q[2], hist_q[1]} == {hist_q[0], cur};
   assign quad_eq = {hist_q[6], hist_q[5], hist_q[4], hist_q[3]} ==
                    {hist_q[2], hist_q[1], hist_q[0], cur};

   always_comb begin
      csc_d = 1'b0;
      if (take && consec_en && hs_q && !cfg_chg) begin
         if (fast_q) csc_d = fill_q >= 4'h7 && quad_eq;
         else csc_d = fill_q >= 4'h3 && pair_eq;
      end
   end

   // ----------------------------------------------------------------
   // Word and channel events, trigger
   // ----------------------------------------------------------------
   // A word is judged per sample; short target pulses may go unseen
   logic word_d, chan_d;
   logic [DEPTH_W-1:0] scnt_q;

   assign word_d = take && word_en && ((smp_data ^ word_val) & word_care & chmask) == '0;
   assign chan_d = take && chan_en && chan_idx < 7'(CH_W) &&
                   chmask[chan_idx] && smp_data[chan_idx] == chan_lvl;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         word_hit <= 1'b0;
         chan_hit <= 1'b0;
         consec_hit <= 1'b0;
         trig <= 1'b0;
         trig_pos <= '0;
         scnt_q <= '0;
      end else begin
         word_hit <= word_d;
         chan_hit <= chan_d;
         consec_hit <= csc_d;
         trig <= word_d || chan_d || csc_d;
         if (take) scnt_q <= scnt_q + DEPTH_W'(1);
         if (word_d || chan_d || csc_d) trig_pos <= scnt_q;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_sec_hs;
      hs_mode && period_sel == PER_5 |=> sec_en == 12'h30f;
   endproperty
   a_sec_hs: assert property (p_sec_hs) else $error("slow hs sections wrong");

   property p_sec_fast;
      hs_mode && period_sel == PER_2P5 |=> sec_en == 12'h103 && pos_tol == 2'h3;
   endproperty
   a_sec_fast: assert property (p_sec_fast) else $error("fast sections wrong");

   property p_gp_per;
      !hs_mode && period_sel < PER_10 |=> period_err && period_eff == PER_10 && !fast_q;
   endproperty
   a_gp_per: assert property (p_gp_per) else $error("fast period in general mode");

   property p_tol;
      hs_mode && period_sel == PER_5 |=> pos_tol == 2'h1;
   endproperty
   a_tol: assert property (p_tol) else $error("tolerance wrong");

   property p_def;
      def_trig <= mem_depth;
   endproperty
   a_def: assert property (p_def) else $error("defined trigger above depth");

   property p_depth;
      hs_mode && period_sel == PER_2P5 && depth_exp == 4'h0 |=> mem_depth == DEPTH_W'(BASE * 4);
   endproperty
   a_depth: assert property (p_depth) else $error("fast depth wrong");

   property p_range;
      hs_mode |=> !range_on && !range_avail;
   endproperty
   a_range: assert property (p_range) else $error("range in hs");

   property p_pair;
      take && consec_en && hs_q && !fast_q && !cfg_chg && fill_q >= 4'h3 &&
      cur == hist_q[1] && hist_q[0] == hist_q[2] |=> consec_hit && trig;
   endproperty
   a_pair: assert property (p_pair) else $error("pair match missed");

   property p_quad;
      consec_hit && $past(fast_q) |-> $past(fill_q) >= 4'h7 && $past(cur) == $past(hist_q[3]);
   endproperty
   a_quad: assert property (p_quad) else $error("quad match false");

   property p_inact;
      chan_hit |-> $past(chmask[chan_idx]);
   endproperty
   a_inact: assert property (p_inact) else $error("inactive channel hit");
endmodule // hs_trigger

`default_nettype wire

/* dv/target_probe.sv */
`timescale 1ns/1ps
`default_nettype none
// -----
// Probed target, one word per request
// -----
module target_probe (
   input wire logic sys_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic req, // present pat
   input wire logic [hst_pkg::CH_W-1:0] pat, // word to present
   input wire logic smp_ready, // word taken
   output logic smp_valid, // word on probes
   output logic [hst_pkg::CH_W-1:0] smp_data // probe levels
);
   import hst_pkg::*;
   // Word stays put until taken, so it can never be missed
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         smp_valid <= 1'b0;
         smp_data <= '0;
      end else if (smp_valid && smp_ready) begin
         smp_valid <= 1'b0;
         // Released lines must not look like the old word
         smp_data <= ~smp_data;
      end else if (req && !smp_valid) begin
         smp_valid <= 1'b1;
         smp_data <= pat;
      end
   end
endmodule // target_probe
`default_nettype wire

/* dv/high_speed_timing_trigger_test.sv */
`timescale 1ns/1ps
`default_nettype none
module high_speed_timing_trigger_test;
   import hst_pkg::*;
   localparam logic [3:0] PER_TAB [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h9, 4'hf};
   logic sys_clk, nrst, hs_mode, ext_clk_req, def_trig_wr, word_en, chan_en, chan_lvl, consec_en, range_en, req;
   logic out_ready, smp_valid, smp_ready, out_valid, period_err, ext_clk_used, range_avail, range_on;
   logic word_hit, chan_hit, consec_hit, trig;
   logic [3:0] period_sel, depth_exp, period_eff;
   logic [6:0] chan_idx;
   logic [11:0] sec_en;
   logic [1:0] pos_tol;
   logic [DEPTH_W-1:0] def_trig_val, mem_depth, def_trig, trig_pos, acc_idx;
   logic [CH_W-1:0] word_val, word_care, pat, smp_data, out_data;
   logic [CH_W-1:0] hist[$], fifo_q[$];
   logic [15:0] lfsr_q;
   int fail_count, cmp_count;

   target_probe u_probe (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .req(req),
      .pat(pat),
      .smp_ready(smp_ready),
      .smp_valid(smp_valid),
      .smp_data(smp_data)
   );
   hs_trigger u_dut (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .hs_mode(hs_mode),
      .period_sel(period_sel),
      .ext_clk_req(ext_clk_req),
      .depth_exp(depth_exp),
      .def_trig_wr(def_trig_wr),
      .def_trig_val(def_trig_val),
      .word_en(word_en),
      .word_val(word_val),
      .word_care(word_care),
      .chan_en(chan_en),
      .chan_idx(chan_idx),
      .chan_lvl(chan_lvl),
      .consec_en(consec_en),
      .range_en(range_en),
      .smp_valid(smp_valid),
      .smp_data(smp_data),
      .smp_ready(smp_ready),
      .out_valid(out_valid),
      .out_data(out_data),
      .out_ready(out_ready),
      .sec_en(sec_en),
      .period_eff(period_eff),
      .period_err(period_err),
      .ext_clk_used(ext_clk_used),
      .pos_tol(pos_tol),
      .mem_depth(mem_depth),
      .def_trig(def_trig),
      .range_avail(range_avail),
      .range_on(range_on),
      .word_hit(word_hit),
      .chan_hit(chan_hit),
      .consec_hit(consec_hit),
      .trig(trig),
      .trig_pos(trig_pos)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // -----
   // Models
   // -----
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction
   function automatic logic [CH_W-1:0] rnd96();
      return {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
   endfunction
   function automatic logic [3:0] eff_per(input logic hs, input logic [3:0] p);
      if (p > PER_1MS) return PER_1MS;
      if (!hs && p < PER_10) return PER_10;
      return p;
   endfunction
   function automatic logic is_fast(input logic hs, input logic [3:0] p);
      return hs && eff_per(hs, p) == PER_2P5;
   endfunction
   function automatic logic [11:0] sec_exp(input logic hs, input logic [3:0] p);
      return !hs ? MASK_GP : is_fast(hs, p) ? MASK_FAST : MASK_HS;
   endfunction
   function automatic logic [CH_W-1:0] ch_mask(input logic [11:0] s);
      for (int i = 0; i < CH_W; i++) ch_mask[i] = s[i / SEC_W];
   endfunction
   function automatic logic [DEPTH_W-1:0] depth_f(input logic hs, input logic [3:0] p, input logic [3:0] e);
      logic [DEPTH_W-1:0] d;
      d = DEPTH_W'(BASE_DEPTH) << (!hs ? DSH_GP : is_fast(hs, p) ? DSH_FAST : DSH_HS);
      return d >> ((e > DEPTH_EXP_MAX) ? DEPTH_EXP_MAX : e);
   endfunction
   // -----
   // Drivers and checks
   // -----
   task automatic chk(input string what, input logic [CH_W-1:0] seen, input logic [CH_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic set_cfg(input logic hs, input logic [3:0] p, input logic [3:0] e);
      logic [15:0] r;
      r = rnd();
      hs_mode = hs;
      period_sel = p;
      depth_exp = e;
      ext_clk_req = r[0];
      range_en = r[1];
      tick(2);
      chk("sec_en", sec_en, sec_exp(hs, p));
      chk("period_eff", period_eff, eff_per(hs, p));
      chk("period_err", period_err, !hs && p < PER_10);
      chk("ext_clk_used", ext_clk_used, r[0] && !hs);
      chk("pos_tol", pos_tol, !hs ? TOL_GP : is_fast(hs, p) ? TOL_FAST : TOL_HS);
      chk("mem_depth", mem_depth, depth_f(hs, p, e));
      chk("range", {range_avail, range_on}, {!hs, r[1] && !hs});
   endtask
   task automatic wr_def(input logic [DEPTH_W-1:0] v, input logic [DEPTH_W-1:0] exp);
      def_trig_val = v;
      def_trig_wr = 1'b1;
      tick(1);
      def_trig_wr = 1'b0;
      chk("def_trig", def_trig, exp);
      // Let an edge pass so a following write never re-raises the strobe in the same step
      tick(1);
   endtask
   task automatic send(input logic [CH_W-1:0] w);
      logic [CH_W-1:0] cm, m;
      logic wh, ch, ec;
      int n;
      cm = ch_mask(sec_exp(hs_mode, period_sel));
      m = w & cm;
      pat = w;
      req = 1'b1;
      tick(1);
      req = 1'b0;
      for (n = 0; n < 20 && smp_valid; n++) tick(1);
      if (n == 20) begin
         fail_count++;
         finish_test();
      end
      hist.push_front(m);
      if (hist.size() > 8) void'(hist.pop_back());
      wh = word_en && ((w ^ word_val) & word_care & cm) == '0;
      ch = chan_en && cm[chan_idx] && w[chan_idx] == chan_lvl;
      ec = consec_en && hs_mode && (is_fast(hs_mode, period_sel) ?
           (hist.size() == 8 && {hist[7], hist[6], hist[5], hist[4]} == {hist[3], hist[2], hist[1], hist[0]}) :
           (hist.size() >= 4 && {hist[3], hist[2]} == {hist[1], hist[0]}));
      chk("word_hit", word_hit, wh);
      chk("chan_hit", chan_hit, ch);
      chk("consec_hit", consec_hit, ec);
      chk("trig", trig, wh | ch | ec);
      if (trig === 1'b1) chk("trig_pos", trig_pos, acc_idx);
      if (out_ready) begin
         chk("out_data", out_data, m);
         chk("out_valid", out_valid, 1'b1);
      end else begin
         fifo_q.push_back(m);
      end
      acc_idx++;
   endtask
   task automatic run(input logic hs, input logic [3:0] p);
      logic [CH_W-1:0] w;
      logic [15:0] r;
      set_cfg(hs, p, 4'h0);
      hist.delete();
      w = rnd96();
      word_val = w;
      word_care = rnd96();
      consec_en = 1'b1;
      // Eleven equal words first: the longest run that must hit
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         chan_idx = 7'(r[15:8] % 96);
         chan_lvl = r[0];
         word_en = r[4] || i < 11;
         chan_en = r[5];
         if (i >= 11 && r[2:1] == 2'h0) w = r[3] ? word_val : rnd96();
         send(w);
      end
   endtask
   // -----
   // Sequence
   // -----
   initial begin
      logic [15:0] r;
      nrst = 1'b0;
      {hs_mode, ext_clk_req, def_trig_wr, word_en, chan_en, chan_lvl, consec_en, range_en, req} = '0;
      period_sel = PER_10;
      depth_exp = 4'h0;
      def_trig_val = '0;
      chan_idx = 7'h00;
      {word_val, word_care, pat} = '0;
      out_ready = 1'b1;
      lfsr_q = 16'h3f42;
      acc_idx = '0;
      fail_count = 0;
      cmp_count = 0;
      tick(12);
      chk("reset", {sec_en, period_eff, pos_tol, range_avail, smp_ready, mem_depth, def_trig, word_hit, chan_hit,
          consec_hit, trig}, {12'hfff, 4'h2, 2'h0, 2'h3, 18'h08000, 18'h00000, 4'h0});
      nrst = 1'b1;
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         set_cfg(i[0], PER_TAB[i / 2], r[3:0]);
      end
      set_cfg(1'b1, PER_5, 4'h0);
      wr_def(18'h3ffff, 18'h10000);
      wr_def(18'h0c000, 18'h0c000);
      set_cfg(1'b1, PER_5, 4'h1);
      chk("def_trig", def_trig, 18'h00000);
      set_cfg(1'b1, PER_2P5, 4'h9);
      wr_def(18'h00100, 18'h00100);
      set_cfg(1'b1, PER_5, 4'h9);
      chk("def_trig", def_trig, 18'h00000);
      run(1'b0, PER_10);
      run(1'b1, PER_5);
      run(1'b1, PER_2P5);
      run(1'b1, PER_1MS);
      run(1'b0, 4'h5);
      // Fill the output buffer with the sink stalled, then drain it
      set_cfg(1'b1, PER_2P5, 4'h3);
      hist.delete();
      out_ready = 1'b0;
      repeat (4) send(rnd96());
      tick(1);
      chk("smp_ready", smp_ready, 1'b0);
      out_ready = 1'b1;
      for (int i = 0; i < 12; i++) begin
         if (out_valid && fifo_q.size() > 0) chk("fifo_head", out_data, fifo_q.pop_front());
         tick(1);
      end
      chk("drained", {fifo_q.size() == 0, out_valid, smp_ready}, 3'h5);
      finish_test();
   end
endmodule // high_speed_timing_trigger_test
`default_nettype wire
